// [verilog/ptr_pkg.sv]
// Constants for the program memory table read block
`default_nettype none
package ptr_pkg;
  localparam int ADDR_W = 13;
  localparam int WORDS = 8192;
  localparam int DATA_W = 16;
  localparam int DMEM_AW = 9;
  localparam int SECTOR_LSB = 8;
  localparam logic [ADDR_W-1:0] LAST_PAGE_BASE = 13'h1F00;
  localparam logic [7:0] HOLDER_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam int HIGH_PTR_BITS = 5;
  typedef enum logic [2:0] {
    PTR_IDLE = 3'b001,
    PTR_FETCH = 3'b010,
    PTR_COMMIT = 3'b100
  } ptr_state_t;
endpackage
`default_nettype wire

// [verilog/ptr_rd_if.sv]
// Carrier between the sequencer and the memory array
`timescale 1ns/1ps
`default_nettype none
interface ptr_rd_if;
  logic rd_en;
  logic [ptr_pkg::ADDR_W-1:0] rd_addr;
  logic [ptr_pkg::DATA_W-1:0] rd_data;
  modport ctl (output rd_en, output rd_addr, input rd_data);
  modport mem (input rd_en, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// [verilog/ptr_mem.sv]
// Program memory array with registered read and load port
`timescale 1ns/1ps
`default_nettype none
module ptr_mem #(
  parameter int WORDS = ptr_pkg::WORDS
) (
  // Clock
  input wire logic core_clk,
  input wire logic clk_en,
  // Read
  ptr_rd_if.mem rd,
  // Image load
  input wire logic load_en,
  input wire logic [ptr_pkg::ADDR_W-1:0] load_addr,
  input wire logic [ptr_pkg::DATA_W-1:0] load_data
);
  logic [ptr_pkg::DATA_W-1:0] array_mem [WORDS];
  logic [ptr_pkg::DATA_W-1:0] rd_data_reg;
  always_ff @(posedge core_clk) begin
    if (clk_en && load_en) begin
      array_mem[load_addr] <= load_data;
    end
  end
  // Word fetched in the first cycle
  always_ff @(posedge core_clk) begin
    if (clk_en && rd.rd_en) begin
      rd_data_reg <= array_mem[rd.rd_addr];
    end
  end
  assign rd.rd_data = rd_data_reg;
endmodule // ptr_mem
`default_nettype wire

// [verilog/ptr_table_read.sv]
// Table read sequencer with pointers and high byte holder
`timescale 1ns/1ps
`default_nettype none
module ptr_table_read (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Pointer writes from the core
  input wire logic tblp_wr,
  input wire logic tbhp_wr,
  input wire logic [7:0] ptr_wdata,
  // Holder software access
  input wire logic holder_wr,
  input wire logic [7:0] holder_wdata,
  output logic [7:0] table_high_byte_holder,
  // Instruction issue
  input wire logic tab_start,
  input wire logic tab_last_page,
  input wire logic tab_extended,
  input wire logic [ptr_pkg::DMEM_AW-1:0] tab_dest,
  output logic tab_busy,
  output logic tab_refused,
  // Destination write
  output logic dmem_we,
  output logic [ptr_pkg::DMEM_AW-1:0] dmem_addr,
  output logic [7:0] dmem_wdata,
  // Memory image load
  input wire logic load_en,
  input wire logic [ptr_pkg::ADDR_W-1:0] load_addr,
  input wire logic [ptr_pkg::DATA_W-1:0] load_data,
  // Pointer readback
  output logic [7:0] tblp_q,
  output logic [7:0] tbhp_q
);
  ptr_rd_if rdi ();
  ptr_pkg::ptr_state_t state_reg, state_next;
  logic [7:0] tblp_reg, tbhp_reg, holder_reg, low_reg;
  logic [ptr_pkg::DMEM_AW-1:0] dest_reg;
  logic last_reg;
  logic we_reg, refused_reg;
  wire logic dest_sector0;
  wire logic accept;
  wire logic [ptr_pkg::ADDR_W-1:0] full_addr;
  wire logic [ptr_pkg::ADDR_W-1:0] last_addr;

  function automatic logic [ptr_pkg::ADDR_W-1:0] join_ptr(
      input logic [7:0] hi, input logic [7:0] lo);
    join_ptr = {hi[ptr_pkg::HIGH_PTR_BITS-1:0], lo};
  endfunction

  assign full_addr = join_ptr(tbhp_reg, tblp_reg);
  assign last_addr = ptr_pkg::LAST_PAGE_BASE | {5'h00, tblp_reg};
  assign dest_sector0 =
    tab_dest[ptr_pkg::DMEM_AW-1:ptr_pkg::SECTOR_LSB] == 1'b0;
  assign accept = tab_start && (state_reg == ptr_pkg::PTR_IDLE)
                  && (tab_extended || dest_sector0);
  assign rdi.rd_en = accept;
  assign rdi.rd_addr = tab_last_page ? last_addr : full_addr;

  // Two cycle sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ptr_pkg::PTR_IDLE: if (accept) state_next = ptr_pkg::PTR_FETCH;
      ptr_pkg::PTR_FETCH: state_next = ptr_pkg::PTR_COMMIT;
      ptr_pkg::PTR_COMMIT: state_next = ptr_pkg::PTR_IDLE;
      default: state_next = ptr_pkg::PTR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ptr_pkg::PTR_IDLE;
      dest_reg <= '0;
      last_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      if (accept) begin
        dest_reg <= tab_dest;
        last_reg <= tab_last_page;
      end
    end
  end

  // Pointer registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tblp_reg <= ptr_pkg::PTR_RST;
      tbhp_reg <= ptr_pkg::PTR_RST;
    end else if (clk_en) begin
      if (tblp_wr) tblp_reg <= ptr_wdata;
      if (tbhp_wr) tbhp_reg <= ptr_wdata & 8'h1F;
    end
  end

  // Commit of both bytes in the second cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      holder_reg <= ptr_pkg::HOLDER_RST;
      low_reg <= 8'h00;
      we_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else if (clk_en) begin
      we_reg <= state_reg == ptr_pkg::PTR_FETCH;
      refused_reg <= tab_start && !accept && state_reg == ptr_pkg::PTR_IDLE;
      if (state_reg == ptr_pkg::PTR_FETCH) begin
        low_reg <= rdi.rd_data[7:0];
        holder_reg <= rdi.rd_data[15:8];
      end else if (holder_wr) begin
        holder_reg <= holder_wdata;
      end
    end
  end

  ptr_mem u_mem (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .rd(rdi.mem),
    .load_en(load_en),
    .load_addr(load_addr),
    .load_data(load_data)
  );

  assign table_high_byte_holder = holder_reg;
  assign dmem_we = we_reg;
  assign dmem_addr = dest_reg;
  assign dmem_wdata = low_reg;
  assign tab_busy = state_reg != ptr_pkg::PTR_IDLE;
  assign tab_refused = refused_reg;
  assign tblp_q = tblp_reg;
  assign tbhp_q = tbhp_reg;

  // Checks
  property p_two_cycle;
    @(posedge core_clk) disable iff (!arst_n)
    (accept && clk_en ##1 clk_en) |-> ##1 dmem_we;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("no commit");
  property p_sector;
    @(posedge core_clk) disable iff (!arst_n)
    (clk_en && tab_start && !tab_busy && !tab_extended &&
      tab_dest[ptr_pkg::SECTOR_LSB]) |=> (tab_refused && !tab_busy);
  endproperty
  a_sector: assert property (p_sector) else $error("bad sector");
  property p_last;
    @(posedge core_clk) disable iff (!arst_n)
    (rdi.rd_en && tab_last_page) |-> rdi.rd_addr == {5'h1F, tblp_reg};
  endproperty
  a_last: assert property (p_last) else $error("last page addr");
  property p_full;
    @(posedge core_clk) disable iff (!arst_n)
    (rdi.rd_en && !tab_last_page) |->
      rdi.rd_addr == {tbhp_reg[4:0], tblp_reg};
  endproperty
  a_full: assert property (p_full) else $error("pointer addr");
  property p_pair;
    @(posedge core_clk) disable iff (!arst_n)
    dmem_we |-> table_high_byte_holder == $past(rdi.rd_data[15:8]) ||
      !$past(clk_en);
  endproperty
  a_pair: assert property (p_pair) else $error("holder mismatch");
  property p_low;
    @(posedge core_clk) disable iff (!arst_n)
    (dmem_we && $past(clk_en)) |-> dmem_wdata == $past(rdi.rd_data[7:0]);
  endproperty
  a_low: assert property (p_low) else $error("low byte");
  property p_hwr;
    @(posedge core_clk) disable iff (!arst_n)
    (clk_en && holder_wr && state_reg != ptr_pkg::PTR_FETCH) |=>
      table_high_byte_holder == $past(holder_wdata);
  endproperty
  a_hwr: assert property (p_hwr) else $error("holder write");
  property p_busy;
    @(posedge core_clk) disable iff (!arst_n)
    (accept && clk_en) |=> tab_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  c_basic: cover property (@(posedge core_clk) accept && !tab_last_page);
  c_last: cover property (@(posedge core_clk) accept && tab_last_page);
  c_refuse: cover property (@(posedge core_clk) tab_refused);

  // Pointer, pulse and freeze checks
  property p_tblp;
    @(posedge core_clk) disable iff (!arst_n)
    (clk_en && tblp_wr) |=> tblp_reg == $past(ptr_wdata);
  endproperty
  a_tblp: assert property (p_tblp) else $error("low pointer");
  property p_tbhp;
    @(posedge core_clk) disable iff (!arst_n)
    (clk_en && tbhp_wr) |=> tbhp_reg == {3'b000, $past(ptr_wdata[4:0])};
  endproperty
  a_tbhp: assert property (p_tbhp) else $error("high pointer");
  property p_we_fetch;
    @(posedge core_clk) disable iff (!arst_n)
    (clk_en && state_reg == ptr_pkg::PTR_FETCH) |=>
      (dmem_we && state_reg == ptr_pkg::PTR_COMMIT);
  endproperty
  a_we_fetch: assert property (p_we_fetch) else $error("late commit");
  property p_pulse;
    @(posedge core_clk) disable iff (!arst_n)
    (dmem_we && clk_en) |=> !dmem_we;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long write");
  property p_ref_idle;
    @(posedge core_clk) disable iff (!arst_n)
    tab_refused |-> !tab_busy;
  endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("refused");
  property p_hold;
    @(posedge core_clk) disable iff (!arst_n)
    (state_reg == ptr_pkg::PTR_IDLE && !accept) |=>
      ($stable(dmem_wdata) && $stable(dmem_addr));
  endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_freeze;
    @(posedge core_clk) disable iff (!arst_n)
    !clk_en |=> $stable(state_reg) && $stable(holder_reg) &&
      $stable(tblp_reg) && $stable(tbhp_reg) && $stable(we_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");

  // Scenario covers
  c_last_commit: cover property (@(posedge core_clk) dmem_we && last_reg);
  c_freeze: cover property (@(posedge core_clk) tab_busy && !clk_en);
endmodule // ptr_table_read
`default_nettype wire

// [dv/ptr_dmem_model.sv]
// Data memory model written by the table read block
`timescale 1ns/1ps
`default_nettype none
module ptr_dmem_model (
  // Clock
  input wire logic core_clk,
  // Destination write
  input wire logic dmem_we,
  input wire logic [ptr_pkg::DMEM_AW-1:0] dmem_addr,
  input wire logic [7:0] dmem_wdata
);
  logic [7:0] mem [0:511];
  // Stores one byte per write pulse
  always_ff @(posedge core_clk) begin
    if (dmem_we === 1'b1) begin
      mem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule // ptr_dmem_model
`default_nettype wire

// [dv/tb_program_memory_table_read.sv]
// Testbench for the table read block
`timescale 1ns/1ps
`default_nettype none
module tb_program_memory_table_read;
  logic core_clk = 0, arst_n = 0, tblp_wr = 0, tbhp_wr = 0, holder_wr = 0;
  logic tab_start = 0, tab_last_page = 0, tab_extended = 0, load_en = 0;
  logic [7:0] ptr_wdata = 8'h00, holder_wdata = 8'h00, holder;
  logic [8:0] tab_dest = 9'h000, dmem_addr;
  logic [12:0] load_addr = 13'h0000;
  logic [15:0] load_data = 16'h0000;
  logic tab_busy, tab_refused, dmem_we, seen;
  logic [7:0] dmem_wdata;
  logic clk_en = 1;
  logic programming_clock_line = 0, programming_serial_data_line = 0;
  logic [7:0] tblp_q, tbhp_q;
  logic [28:0] prog_shift = 29'h00000000;
  int err_total = 0, checks = 0;
  always #25 core_clk = ~core_clk;
  ptr_table_read dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .tblp_wr(tblp_wr), .tbhp_wr(tbhp_wr), .ptr_wdata(ptr_wdata),
    .holder_wr(holder_wr), .holder_wdata(holder_wdata),
    .table_high_byte_holder(holder), .tab_start(tab_start),
    .tab_last_page(tab_last_page), .tab_extended(tab_extended),
    .tab_dest(tab_dest), .tab_busy(tab_busy), .tab_refused(tab_refused),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .tblp_q(tblp_q), .tbhp_q(tbhp_q));
  // Tool side receiver, one bit per tool clock
  always @(posedge programming_clock_line) begin
    prog_shift <= {prog_shift[27:0], programming_serial_data_line};
  end
  ptr_dmem_model model (.core_clk(core_clk), .dmem_we(dmem_we),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Programming tool: address then data, serially
  // Only this task drives the two programming lines
  task ld(input logic [12:0] a, input logic [15:0] d);
    logic [28:0] frame;
    frame = {a, d};
    for (int i = 28; i >= 0; i--) begin
      @(negedge core_clk);
      programming_clock_line = 0;
      programming_serial_data_line = frame[i];
      @(negedge core_clk);
      programming_clock_line = 1;
    end
    @(negedge core_clk);
    programming_clock_line = 0;
    chk({3'h0, prog_shift[28:16]}, {3'h0, a});
    chk(prog_shift[15:0], d);
    load_en = 1;
    load_addr = prog_shift[28:16];
    load_data = prog_shift[15:0];
    @(negedge core_clk);
    load_en = 0;
  endtask
  task ptr(input logic [7:0] lo, input logic [7:0] hi);
    @(negedge core_clk);
    tblp_wr = 1;
    ptr_wdata = lo;
    @(negedge core_clk);
    tblp_wr = 0;
    tbhp_wr = 1;
    ptr_wdata = hi;
    @(negedge core_clk);
    tbhp_wr = 0;
    chk(tblp_q, lo);
    chk(tbhp_q, {3'b000, hi[4:0]});
  endtask
  // Interrupt-free issue, one read at a time
  task rd(input logic lp, ex, input logic [8:0] d, input logic [15:0] w);
    @(negedge core_clk);
    {tab_last_page, tab_extended, tab_dest, tab_start} = {lp, ex, d, 1'b1};
    @(negedge core_clk);
    tab_start = 0;
    chk(dmem_we, 1'b0);
    chk(tab_busy, 1'b1);
    @(negedge core_clk);
    chk(dmem_we, 1'b1);
    chk(dmem_addr, d);
    chk({holder, dmem_wdata}, w);
    @(negedge core_clk);
    chk({dmem_we, tab_busy}, 2'b00);
    chk(model.mem[d], w[7:0]);
  endtask
  task t_basic;
    ptr(8'h06, 8'h1F);
    rd(0, 0, 9'h020, 16'h001A);
    ptr(8'h23, 8'h01);
    rd(0, 0, 9'h021, 16'h5AE1);
    ptr(8'hFF, 8'h1F);
    rd(0, 1, 9'h1F0, 16'hC3B7);
    $display("basic read test done");
  endtask
  task t_last;
    ptr(8'h05, 8'h00);
    rd(1, 0, 9'h031, 16'h000F);
    $display("last page test done");
  endtask
  task t_sector;
    @(negedge core_clk);
    {tab_last_page, tab_extended, tab_dest, tab_start} = {2'b00, 9'h140, 1'b1};
    @(negedge core_clk);
    tab_start = 0;
    seen = tab_refused;
    chk(dmem_we, 1'b0);
    @(negedge core_clk);
    seen = seen | tab_refused;
    chk({seen, dmem_we}, 2'b10);
    rd(1, 1, 9'h141, 16'h000F);
    $display("sector test done");
  endtask
  task t_holder;
    @(negedge core_clk);
    holder_wr = 1;
    holder_wdata = 8'hA5;
    @(negedge core_clk);
    holder_wr = 0;
    chk(holder, 8'hA5);
    ptr(8'h23, 8'h01);
    rd(0, 0, 9'h022, 16'h5AE1);
    $display("holder test done");
  endtask
  task t_freeze;
    ptr(8'h06, 8'h1F);
    @(negedge core_clk);
    {tab_last_page, tab_extended, tab_dest, tab_start} = {2'b00, 9'h023, 1'b1};
    @(negedge core_clk);
    {tab_start, clk_en} = 2'b00;
    repeat (2) @(negedge core_clk);
    chk({dmem_we, tab_busy}, 2'b01);
    clk_en = 1;
    @(negedge core_clk);
    chk({holder, dmem_wdata}, 16'h001A);
    chk({dmem_we, dmem_addr}, 10'h223);
    @(negedge core_clk);
    chk({dmem_we, tab_busy}, 2'b00);
    $display("clock enable test done");
  endtask
  task t_reset;
    ptr(8'h06, 8'h1F);
    @(negedge core_clk);
    {tab_last_page, tab_extended, tab_dest, tab_start} = {2'b00, 9'h024, 1'b1};
    @(negedge core_clk);
    {tab_start, arst_n} = 2'b00;
    @(negedge core_clk);
    chk({holder, dmem_wdata}, 16'h0000);
    chk({tblp_q, tbhp_q}, 16'h0000);
    chk({4'h0, dmem_addr, dmem_we, tab_busy, tab_refused}, 16'h0000);
    arst_n = 1;
    ptr(8'h23, 8'h01);
    rd(0, 0, 9'h024, 16'h5AE1);
    $display("reset test done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1;
    ld(13'h1F06, 16'h001A);
    ld(13'h1F05, 16'h000F);
    ld(13'h1FFF, 16'hC3B7);
    ld(13'h0123, 16'h5AE1);
    t_basic();
    t_last();
    t_sector();
    t_holder();
    t_freeze();
    t_reset();
    report_and_stop();
  end
  initial begin
    // Run needs about 16100 ns; about six times that is a hang
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule // tb_program_memory_table_read
`default_nettype wire
